// ---- verilog/ghpm_defs.vh ----
// Constants for the pin block with hot-plug signal mapping.
`ifndef GHPM_DEFS_VH
`define GHPM_DEFS_VH
`define GHPM_ADDR_W       12
`define GHPM_PIN_CNT      9
`define GHPM_GRP_CNT      5
`define GHPM_SEL_W        5
`define GHPM_PORT_CNT     31
`define GHPM_MAP_W        25
`define GHPM_HP_IN_BASE   0
`define GHPM_HP_OUT_BASE  5
`define GHPM_OFF_FUNC     12'hA90
`define GHPM_OFF_DIR      12'hAA8
`define GHPM_OFF_DATA     12'hAB0
`define GHPM_OFF_MAP      12'hAB8
`define GHPM_SEL_NONE     5'h1F
`define GHPM_FUNC_RST     9'h000
`define GHPM_DIR_RST      9'h000
`define GHPM_DATA_RST     9'h000
`define GHPM_MAP_RST      25'h1FFFFFF
`define GHPM_RESP_OKAY    2'h0
`define GHPM_RESP_SLVERR  2'h2
`endif

// ---- verilog/ghpm_top.v ----
// Pin block: direction, data, function select and hot-plug group mapping over AXI4-Lite.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ghpm_defs.vh"

module ghpm_top (
	input  wire                          sys_clk,
	input  wire                          rst,
	input  wire                          clk_en,
	input  wire [`GHPM_ADDR_W-1:0]       s_axi_awaddr,
	input  wire [2:0]                    s_axi_awprot,
	input  wire                          s_axi_awvalid,
	output wire                          s_axi_awready,
	input  wire [31:0]                   s_axi_wdata,
	input  wire [3:0]                    s_axi_wstrb,
	input  wire                          s_axi_wvalid,
	output wire                          s_axi_wready,
	output wire [1:0]                    s_axi_bresp,
	output wire                          s_axi_bvalid,
	input  wire                          s_axi_bready,
	input  wire [`GHPM_ADDR_W-1:0]       s_axi_araddr,
	input  wire [2:0]                    s_axi_arprot,
	input  wire                          s_axi_arvalid,
	output wire                          s_axi_arready,
	output wire [31:0]                   s_axi_rdata,
	output wire [1:0]                    s_axi_rresp,
	output wire                          s_axi_rvalid,
	input  wire                          s_axi_rready,
	input  wire [`GHPM_PIN_CNT-1:0]      pin_in,
	output wire [`GHPM_PIN_CNT-1:0]      pin_out,
	output wire [`GHPM_PIN_CNT-1:0]      pin_oe_n,
	input  wire [`GHPM_PORT_CNT-1:0]     port_hp_indicator,
	output wire [`GHPM_PORT_CNT-1:0]     port_hp_presence
);

	// Register state.
	reg  [`GHPM_PIN_CNT-1:0]  pin_function_select_bits_ff;
	reg  [`GHPM_PIN_CNT-1:0]  nxt_pin_function_select_bits;
	reg  [`GHPM_PIN_CNT-1:0]  pin_direction_bits_ff;
	reg  [`GHPM_PIN_CNT-1:0]  nxt_pin_direction_bits;
	reg  [`GHPM_PIN_CNT-1:0]  pin_level_bits_ff;
	reg  [`GHPM_PIN_CNT-1:0]  nxt_pin_level_bits;
	reg  [`GHPM_MAP_W-1:0]    hotplug_map_ff;
	reg  [`GHPM_MAP_W-1:0]    nxt_hotplug_map;

	// Pin synchroniser; the first stage feeds only the second.
	reg  [`GHPM_PIN_CNT-1:0]  pin_meta_ff;
	reg  [`GHPM_PIN_CNT-1:0]  pin_sync_ff;

	// Pin and port outputs.
	reg  [`GHPM_PIN_CNT-1:0]  pin_out_ff;
	reg  [`GHPM_PIN_CNT-1:0]  pin_oe_n_ff;
	reg  [`GHPM_PORT_CNT-1:0] port_hp_presence_ff;
	wire [`GHPM_PIN_CNT-1:0]  nxt_pin_out;
	wire [`GHPM_PIN_CNT-1:0]  nxt_pin_oe_n;
	wire [`GHPM_PORT_CNT-1:0] nxt_port_hp_presence;

	// Bus slave state.
	reg                       aw_held_ff;
	reg  [`GHPM_ADDR_W-1:0]   aw_addr_ff;
	reg                       w_held_ff;
	reg  [31:0]               w_data_ff;
	reg  [3:0]                w_strb_ff;
	reg                       awready_ff;
	reg                       wready_ff;
	reg                       bvalid_ff;
	reg  [1:0]                bresp_ff;
	reg                       arready_ff;
	reg                       rvalid_ff;
	reg  [1:0]                rresp_ff;
	reg  [31:0]               rdata_ff;

	wire                      aw_take;
	wire                      w_take;
	wire                      ar_take;
	wire                      aw_have;
	wire                      w_have;
	wire                      wr_fire;
	wire [`GHPM_ADDR_W-1:0]   wr_addr;
	wire [31:0]               wr_data;
	wire [3:0]                wr_strb;
	wire [31:0]               lane_mask;
	wire                      wr_hit;
	wire                      nxt_aw_held;
	wire                      nxt_w_held;
	wire                      nxt_bvalid;
	wire                      nxt_rvalid;
	reg  [31:0]               rd_word;
	reg                       rd_hit;

	// Hot-plug group decode.
	wire [`GHPM_SEL_W-1:0]    grp_sel [0:`GHPM_GRP_CNT-1];
	wire [`GHPM_GRP_CNT-1:0]  grp_attached;
	wire [`GHPM_GRP_CNT-1:0]  grp_drive;
	wire [`GHPM_GRP_CNT-1:0]  grp_sense;
	wire [`GHPM_PIN_CNT-1:0]  gpio_out_mask;
	wire [`GHPM_GRP_CNT*`GHPM_PORT_CNT-1:0] grp_port_drv;

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign pin_out       = pin_out_ff;
	assign pin_oe_n      = pin_oe_n_ff;
	assign port_hp_presence = port_hp_presence_ff;

	// Address and data are taken independently; the write fires once both are held or taken this cycle.
	assign aw_take = s_axi_awvalid & awready_ff;
	assign w_take  = s_axi_wvalid & wready_ff;
	assign ar_take = s_axi_arvalid & arready_ff;
	assign aw_have = aw_held_ff | aw_take;
	assign w_have  = w_held_ff | w_take;
	assign wr_fire = aw_have & w_have & ~bvalid_ff;
	assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
	assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
	assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
	assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign wr_hit  = (wr_addr == `GHPM_OFF_FUNC) | (wr_addr == `GHPM_OFF_DIR) |
	                 (wr_addr == `GHPM_OFF_DATA) | (wr_addr == `GHPM_OFF_MAP);
	assign nxt_aw_held = aw_have & ~wr_fire;
	assign nxt_w_held  = w_have & ~wr_fire;
	assign nxt_bvalid  = wr_fire | (bvalid_ff & ~s_axi_bready);
	assign nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready);

	// Pins that software may drive through the data field. Bits aimed at any other pin are
	// dropped, not stored, so a pin turned into an output later drives the level it last held.
	assign gpio_out_mask = ~pin_function_select_bits_ff & pin_direction_bits_ff;

	// Register writes honour byte strobes; reserved bits are not stored.
	always @* begin
		nxt_pin_function_select_bits = pin_function_select_bits_ff;
		nxt_pin_direction_bits       = pin_direction_bits_ff;
		nxt_pin_level_bits           = pin_level_bits_ff;
		nxt_hotplug_map              = hotplug_map_ff;
		if (wr_fire) begin
			case (wr_addr)
				`GHPM_OFF_FUNC: begin
					nxt_pin_function_select_bits = (pin_function_select_bits_ff &
						~lane_mask[`GHPM_PIN_CNT-1:0]) |
						(wr_data[`GHPM_PIN_CNT-1:0] & lane_mask[`GHPM_PIN_CNT-1:0]);
				end
				`GHPM_OFF_DIR: begin
					nxt_pin_direction_bits = (pin_direction_bits_ff &
						~lane_mask[`GHPM_PIN_CNT-1:0]) |
						(wr_data[`GHPM_PIN_CNT-1:0] & lane_mask[`GHPM_PIN_CNT-1:0]);
				end
				`GHPM_OFF_DATA: begin
					nxt_pin_level_bits = (pin_level_bits_ff &
						~(lane_mask[`GHPM_PIN_CNT-1:0] & gpio_out_mask)) |
						(wr_data[`GHPM_PIN_CNT-1:0] &
						lane_mask[`GHPM_PIN_CNT-1:0] & gpio_out_mask);
				end
				`GHPM_OFF_MAP: begin
					nxt_hotplug_map = (hotplug_map_ff & ~lane_mask[`GHPM_MAP_W-1:0]) |
						(wr_data[`GHPM_MAP_W-1:0] & lane_mask[`GHPM_MAP_W-1:0]);
				end
				default: begin
					nxt_hotplug_map = hotplug_map_ff;
				end
			endcase
		end
	end

	// Read decode; unmapped offsets answer zero with an error.
	// The synchroniser clears to zero, so the data field reads zero for two cycles after reset.
	always @* begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			`GHPM_OFF_FUNC: begin
				rd_word[`GHPM_PIN_CNT-1:0] = pin_function_select_bits_ff;
			end
			`GHPM_OFF_DIR: begin
				rd_word[`GHPM_PIN_CNT-1:0] = pin_direction_bits_ff;
			end
			`GHPM_OFF_DATA: begin
				rd_word[`GHPM_PIN_CNT-1:0] = pin_sync_ff;
			end
			`GHPM_OFF_MAP: begin
				rd_word[`GHPM_MAP_W-1:0] = hotplug_map_ff;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Per group: attachment and the sensed input of that group.
	genvar g;
	generate
		for (g = 0; g < `GHPM_GRP_CNT; g = g + 1) begin : grp_gen
			assign grp_sel[g] = hotplug_map_ff[g*`GHPM_SEL_W +: `GHPM_SEL_W];
			assign grp_attached[g] = (grp_sel[g] != `GHPM_SEL_NONE);
			// Input level counts only when attached and the pin runs its alternate function.
			assign grp_sense[g] = grp_attached[g] &
				pin_function_select_bits_ff[`GHPM_HP_IN_BASE + g] &
				pin_sync_ff[`GHPM_HP_IN_BASE + g];
			// Drive the attached port's indicator, else drive low.
			assign grp_drive[g] = grp_attached[g] &
				(|grp_port_drv[g*`GHPM_PORT_CNT +: `GHPM_PORT_CNT]);
		end
	endgenerate

	// Per port: OR of every group attached to it, so a port may own several groups.
	genvar p;
	generate
		for (p = 0; p < `GHPM_PORT_CNT; p = p + 1) begin : port_gen
			wire [`GHPM_GRP_CNT-1:0] hit;
			genvar h;
			for (h = 0; h < `GHPM_GRP_CNT; h = h + 1) begin : hit_gen
				// The port number is compared, never used as an index, so the unattached
				// code cannot reach past the last port.
				wire sel_match;
				assign sel_match = ({{(32-`GHPM_SEL_W){1'b0}}, grp_sel[h]} == p);
				assign hit[h] = grp_sense[h] & sel_match;
				assign grp_port_drv[h*`GHPM_PORT_CNT + p] =
					port_hp_indicator[p] & sel_match;
			end
			assign nxt_port_hp_presence[p] = |hit;
		end
	endgenerate

	// Per pin drive. Pins below the output base carry group inputs in alternate mode,
	// so they are never driven there; the upper pins carry group outputs.
	// Group four has no output pin, so its output is not brought out.
	genvar n;
	generate
		for (n = 0; n < `GHPM_PIN_CNT; n = n + 1) begin : pin_gen
			if (n < `GHPM_HP_OUT_BASE) begin : in_pin
				assign nxt_pin_oe_n[n] = pin_function_select_bits_ff[n] ?
					1'b1 : ~pin_direction_bits_ff[n];
				assign nxt_pin_out[n] = pin_function_select_bits_ff[n] ?
					1'b0 : pin_level_bits_ff[n];
			end else begin : out_pin
				assign nxt_pin_oe_n[n] = pin_function_select_bits_ff[n] ?
					1'b0 : ~pin_direction_bits_ff[n];
				assign nxt_pin_out[n] = pin_function_select_bits_ff[n] ?
					grp_drive[n-`GHPM_HP_OUT_BASE] : pin_level_bits_ff[n];
			end
		end
	endgenerate

	// Register state. All state freezes while the clock enable is low.
	always @(posedge sys_clk) begin
		if (rst) begin
			pin_function_select_bits_ff <= `GHPM_FUNC_RST;
			pin_direction_bits_ff       <= `GHPM_DIR_RST;
			pin_level_bits_ff           <= `GHPM_DATA_RST;
			hotplug_map_ff              <= `GHPM_MAP_RST;
		end else if (clk_en) begin
			pin_function_select_bits_ff <= nxt_pin_function_select_bits;
			pin_direction_bits_ff       <= nxt_pin_direction_bits;
			pin_level_bits_ff           <= nxt_pin_level_bits;
			hotplug_map_ff              <= nxt_hotplug_map;
		end
	end

	// Pin side: synchroniser, pin drive and port presence.
	always @(posedge sys_clk) begin
		if (rst) begin
			pin_meta_ff                 <= {`GHPM_PIN_CNT{1'b0}};
			pin_sync_ff                 <= {`GHPM_PIN_CNT{1'b0}};
			pin_out_ff                  <= {`GHPM_PIN_CNT{1'b0}};
			pin_oe_n_ff                 <= {`GHPM_PIN_CNT{1'b1}};
			port_hp_presence_ff         <= {`GHPM_PORT_CNT{1'b0}};
		end else if (clk_en) begin
			pin_meta_ff                 <= pin_in;
			pin_sync_ff                 <= pin_meta_ff;
			pin_out_ff                  <= nxt_pin_out;
			pin_oe_n_ff                 <= nxt_pin_oe_n;
			port_hp_presence_ff         <= nxt_port_hp_presence;
		end
	end

	// Bus handshake registers. Ready is dropped while a word is held or a response waits,
	// which keeps at most one write and one read in flight.
	// A master must hold off while the clock enable is low: ready stays up then, but
	// nothing is taken.
	always @(posedge sys_clk) begin
		if (rst) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= {`GHPM_ADDR_W{1'b0}};
			w_held_ff  <= 1'b0;
			w_data_ff  <= 32'h00000000;
			w_strb_ff  <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `GHPM_RESP_OKAY;
		end else if (clk_en) begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			if (wr_fire) begin
				bresp_ff <= wr_hit ? `GHPM_RESP_OKAY : `GHPM_RESP_SLVERR;
			end
		end
	end

	// Read channel; it runs apart from the write side.
	always @(posedge sys_clk) begin
		if (rst) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= `GHPM_RESP_OKAY;
			rdata_ff   <= 32'h00000000;
		end else if (clk_en) begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? `GHPM_RESP_OKAY : `GHPM_RESP_SLVERR;
			end
		end
	end

endmodule // ghpm_top

// ---- testbench/ghpm_asserts.sv ----
// Concurrent checks on the ports of the pin block.
`timescale 1ns/1ps
`include "ghpm_defs.vh"
module ghpm_asserts (
	input wire        sys_clk,
	input wire        rst,
	input wire        clk_en,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [8:0]  pin_out,
	input wire [8:0]  pin_oe_n,
	input wire [30:0] port_hp_indicator,
	input wire [30:0] port_hp_presence
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response not held");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_ar_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_ref: assert property (p_ar_ref) else $error("read taken while busy");
	property p_aw_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_ref: assert property (p_aw_ref) else $error("write taken while busy");
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read response late");
	// Drive enables only move as a result of a register write.
	property p_oe_src; $changed(pin_oe_n) |-> $past(s_axi_bvalid); endproperty
	a_oe_src: assert property (p_oe_src) else $error("enable moved unprompted");
	property p_out_src;
		$changed(pin_out) |-> $past(s_axi_bvalid) ||
			($past(port_hp_indicator) != $past(port_hp_indicator, 2));
	endproperty
	a_out_src: assert property (p_out_src) else $error("pin value moved unprompted");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	// With the clock enable low the pin outputs, port presence and the two bus valids may not move.
	property p_freeze;
		!clk_en |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(port_hp_presence) &&
			$stable(s_axi_bvalid) && $stable(s_axi_rvalid);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	c_pres: cover property ($rose(|port_hp_presence));
	c_frz: cover property (!clk_en);
endmodule // ghpm_asserts
bind ghpm_top ghpm_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .port_hp_indicator(port_hp_indicator),
	.port_hp_presence(port_hp_presence));

// ---- testbench/ghpm_board_model.sv ----
// Board-side model of the nine pins.
`timescale 1ns/1ps
module ghpm_board_model (
	input  wire logic [8:0] pin_out,
	input  wire logic [8:0] pin_oe_n,
	input  wire logic [8:0] board_lvl,
	output wire logic [8:0] pin_in
);
	// A released pin is pulled by the board, so it never keeps a stale driven value.
	assign pin_in = (pin_oe_n & board_lvl) | (~pin_oe_n & pin_out);
endmodule // ghpm_board_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the pin block.
`timescale 1ns/1ps
`include "ghpm_defs.vh"
module testbench;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} ghpm_row_t;
	logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [8:0]  pin_in, pin_out, pin_oe_n, board_lvl = 9'h0AA;
	logic [30:0] port_hp_indicator = 31'h00000000, port_hp_presence;
	int          errors = 0, checks_done = 0;
	ghpm_row_t   rows[7] = '{
		'{`GHPM_OFF_DIR, 32'hFFFFFFFF, 32'h000001FF, `GHPM_RESP_OKAY},
		'{`GHPM_OFF_FUNC, 32'h000001AA, 32'h000001AA, `GHPM_RESP_OKAY},
		'{`GHPM_OFF_FUNC, 32'h00000000, 32'h00000000, `GHPM_RESP_OKAY},
		'{`GHPM_OFF_MAP, 32'h00000000, 32'h00000000, `GHPM_RESP_OKAY},
		'{`GHPM_OFF_MAP, 32'hFFFFFFFF, 32'h01FFFFFF, `GHPM_RESP_OKAY},
		'{12'h004, 32'hFFFFFFFF, 32'h00000000, `GHPM_RESP_SLVERR},
		'{`GHPM_OFF_DIR, 32'h000000FF, 32'h000000FF, `GHPM_RESP_OKAY}};
	ghpm_top dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.port_hp_indicator(port_hp_indicator), .port_hp_presence(port_hp_presence));
	ghpm_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_lvl(board_lvl),
		.pin_in(pin_in));
	always #20 sys_clk = ~sys_clk;
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task conclude;
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rsp);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				chk("bresp", 32'(s_axi_bresp), 32'(rsp));
				s_axi_bready <= 1'b0;
				return;
			end
		end
		errors++;
		conclude;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rsp);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				chk("rdata", s_axi_rdata, exp);
				chk("rresp", 32'(s_axi_rresp), 32'(rsp));
				s_axi_rready <= 1'b0;
				return;
			end
		end
		errors++;
		conclude;
	endtask
	task settle;
		repeat (6) @(posedge sys_clk);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk("oe_rst", 32'(pin_oe_n), 32'h000001FF);
		chk("pres_rst", 32'(port_hp_presence), 32'h00000000);
		rd(`GHPM_OFF_MAP, 32'h01FFFFFF, `GHPM_RESP_OKAY);
		rd(`GHPM_OFF_DIR, 32'h00000000, `GHPM_RESP_OKAY);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].q, rows[i].r);
		end
		// Pins 0..7 drive, pin 8 listens to the board.
		wr(`GHPM_OFF_DATA, 32'h00000155, `GHPM_RESP_OKAY);
		settle;
		chk("oe_gp", 32'(pin_oe_n), 32'h00000100);
		chk("out_gp", 32'(pin_out[7:0]), 32'h00000055);
		rd(`GHPM_OFF_DATA, 32'h00000055, `GHPM_RESP_OKAY);
		wr(`GHPM_OFF_DIR, 32'h00000000, `GHPM_RESP_OKAY);
		settle;
		chk("oe_in", 32'(pin_oe_n), 32'h000001FF);
		rd(`GHPM_OFF_DATA, 32'h000000AA, `GHPM_RESP_OKAY);
		// Data written to inputs is dropped, so the old level returns.
		wr(`GHPM_OFF_DATA, 32'h00000000, `GHPM_RESP_OKAY);
		wr(`GHPM_OFF_DIR, 32'h000000FF, `GHPM_RESP_OKAY);
		settle;
		chk("out_keep", 32'(pin_out[7:0]), 32'h00000055);
		board_lvl <= 9'h1FF;
		port_hp_indicator <= 31'h7FFFFFFF;
		wr(`GHPM_OFF_FUNC, 32'h000001FF, `GHPM_RESP_OKAY);
		wr(`GHPM_OFF_DIR, 32'h000001FF, `GHPM_RESP_OKAY);
		settle;
		chk("oe_alt", 32'(pin_oe_n), 32'h0000001F);
		chk("out_none", 32'(pin_out[8:5]), 32'h00000000);
		chk("pres_none", 32'(port_hp_presence), 32'h00000000);
		// Group 0 to port 3, group 1 to port 7, the rest unattached.
		wr(`GHPM_OFF_MAP, 32'h01FFFCE3, `GHPM_RESP_OKAY);
		settle;
		chk("out_map", 32'(pin_out[8:5]), 32'h00000003);
		chk("pres_map", 32'(port_hp_presence), 32'h00000088);
		rd(`GHPM_OFF_DATA, 32'h0000007F, `GHPM_RESP_OKAY);
		// Frozen clock enable: the board drops pins 0 and 1, presence must wait.
		clk_en <= 1'b0;
		board_lvl <= 9'h1FC;
		repeat (4) @(posedge sys_clk);
		chk("pres_frz", 32'(port_hp_presence), 32'h00000088);
		clk_en <= 1'b1;
		settle;
		chk("pres_low", 32'(port_hp_presence), 32'h00000000);
		// Reset in mid-run returns every select to unattached and releases the pins.
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk("oe_rst2", 32'(pin_oe_n), 32'h000001FF);
		chk("out_rst2", 32'(pin_out), 32'h00000000);
		rd(`GHPM_OFF_MAP, 32'h01FFFFFF, `GHPM_RESP_OKAY);
		rd(`GHPM_OFF_DATA, 32'h000001FC, `GHPM_RESP_OKAY);
		// Only byte lane 0 enabled: bit 8 of the direction field keeps its old value.
		s_axi_wstrb <= 4'h1;
		wr(`GHPM_OFF_DIR, 32'h000001FF, `GHPM_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(`GHPM_OFF_DIR, 32'h000000FF, `GHPM_RESP_OKAY);
		conclude;
	end
endmodule // testbench
